/* File: verilog/fdi_input_port.sv */
// Eight-channel filtered digital input port with read-only input byte and indicators.
// Behaviour
// - One input byte at offset zero, bit n is filtered channel n.
// - Object index 6000h, with od_ecat_in low, returns the whole input byte.
// - With od_ecat_in high, index 6000h plus slot, subindex 01h..08h returns channel 0..7.
// - No output bytes; output data from the head module is ignored.
// - Standard variant accepts a change only after 3 ms.
// - Fast variant uses a 0.5 ms filter, otherwise identical.
// - Eight channels, each with its own status indicator.
// - Green channel indicator lit while that channel reads one.
// - Bus loss without configuration error, with or without module error, shows run off and fault on.
// - Configuration error flashes run and fault indicators.
`timescale 1ns/10ps
module fdi_input_port
#(
    parameter bit FAST_VARIANT = 1'b0,
    parameter int STD_CYCLES   = fdi_pkg::FDI_CYC_STD,
    parameter int FAST_CYCLES  = fdi_pkg::FDI_CYC_FAST,
    parameter int FLASH_CYCLES = fdi_pkg::FDI_FLASH_CYC
) (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [7:0]           input_channel_in,
    input  wire logic                 rd_in,
    input  wire logic [7:0]           addr_in,
    input  wire logic                 od_rd_in,
    input  wire logic [15:0]          object_index_in,
    input  wire logic [7:0]           object_subindex_in,
    input  wire logic [7:0]           ecat_slot_in,
    input  wire logic                 od_ecat_in,
    input  wire logic                 wr_in,
    input  wire logic [7:0]           wdata_in,
    input  wire logic                 bus_ok_in,
    input  wire logic                 module_err_in,
    input  wire logic                 config_err_in,
    output logic [7:0]                rdata_out,
    output logic                      rvalid_out,
    output logic                      rerr_out,
    output logic [7:0]                input_state_byte_out,
    output logic [7:0]                channel_led_out,
    output logic                      run_indicator_out,
    output logic                      module_fault_indicator_out
);
    import fdi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    localparam int           FILT_CYC = FAST_VARIANT ? FAST_CYCLES : STD_CYCLES;
    localparam logic [FDI_CNT_W-1:0] FILT_MAX = FDI_CNT_W'(FILT_CYC - 1);
    localparam logic [FDI_FLASH_W-1:0] FLASH_MAX = FDI_FLASH_W'(FLASH_CYCLES - 1);

    typedef struct packed {
        logic [7:0]                        stable;
        logic [7:0]                        valid;
        logic [7:0][FDI_CNT_W-1:0]         cnt;
        logic [FDI_FLASH_W-1:0]            flash_cnt;
        logic                              flash;
        logic [7:0]                        rdata;
        logic                              rvalid;
        logic                              rerr;
        logic [7:0]                        leds;
        logic                              run;
        logic                              fault;
    } fdi_state_t;

    fdi_state_t st;
    fdi_state_t next_st;
    logic [7:0] shown;
    logic [15:0] ecat_index;
    logic [7:0] sub_ch;

    assign shown      = st.stable & st.valid;
    assign ecat_index = FDI_IDX_INPUT + {8'h00, ecat_slot_in};
    assign sub_ch     = object_subindex_in - FDI_SUB_FIRST;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        // A first valid level also needs the full stable time, so reset noise never shows.
        for (int i = 0; i < FDI_NUM_CH; i++) begin
            if (input_channel_in[i] == st.stable[i] && st.valid[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.cnt[i] == FILT_MAX) begin
                next_st.stable[i] = input_channel_in[i];
                next_st.valid[i]  = 1'b1;
                next_st.cnt[i]    = '0;
            end else if (!st.valid[i] && input_channel_in[i] != st.stable[i]) begin
                next_st.stable[i] = input_channel_in[i];
                next_st.cnt[i]    = '0;
            end else begin
                next_st.cnt[i] = st.cnt[i] + 1'b1;
            end
        end
        next_st.leds = shown;
        if (st.flash_cnt == FLASH_MAX) begin
            next_st.flash_cnt = '0;
            next_st.flash     = ~st.flash;
        end else begin
            next_st.flash_cnt = st.flash_cnt + 1'b1;
        end
        if (config_err_in) begin
            next_st.run   = st.flash;
            next_st.fault = st.flash;
        end else if (!bus_ok_in) begin
            next_st.run   = 1'b0;
            next_st.fault = 1'b1;
        end else begin
            next_st.run   = 1'b1;
            next_st.fault = module_err_in;
        end
        // Writes carry nothing: the port owns no output image.
        // Refused reads still answer, so the head module never waits on a silent port.
        next_st.rvalid = rd_in | od_rd_in;
        next_st.rerr   = 1'b0;
        next_st.rdata  = 8'h00;
        if (rd_in) begin
            if (addr_in == FDI_OFS_INPUT_STATE) begin
                next_st.rdata = shown;
            end else begin
                next_st.rerr = 1'b1;
            end
        end else if (od_rd_in) begin
            if (!od_ecat_in && object_index_in == FDI_IDX_INPUT) begin
                next_st.rdata = shown;
            end else if (od_ecat_in && object_index_in == ecat_index
                         && object_subindex_in >= FDI_SUB_FIRST && object_subindex_in <= FDI_SUB_LAST) begin
                next_st.rdata = {7'h00, shown[sub_ch[2:0]]};
            end else begin
                next_st.rerr = 1'b1;
            end
        end
        if (!rst_n_in) begin
            next_st        = '0;
            next_st.stable = FDI_INPUT_RESET;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign rdata_out                  = st.rdata;
    assign rvalid_out                 = st.rvalid;
    assign rerr_out                   = st.rerr;
    assign input_state_byte_out       = st.leds;
    assign channel_led_out            = st.leds;
    assign run_indicator_out          = st.run;
    assign module_fault_indicator_out = st.fault;

    ////////////////////////////////////////////////////////////////////////
    property p_byte_read;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_in && addr_in == FDI_OFS_INPUT_STATE |=> rvalid_out && !rerr_out && rdata_out == $past(shown);
    endproperty
    a_byte_read: assert property (p_byte_read) else $error("Input byte read wrong.");

    property p_od_read;
        @(posedge clk_in) disable iff (!rst_n_in)
        od_rd_in && !rd_in && !od_ecat_in && object_index_in == 16'h6000 |=> rdata_out == $past(shown);
    endproperty
    a_od_read: assert property (p_od_read) else $error("Object read wrong.");

    property p_ecat_read;
        @(posedge clk_in) disable iff (!rst_n_in)
        od_rd_in && !rd_in && od_ecat_in && object_index_in == ecat_index && object_subindex_in == 8'h01
        |=> rdata_out == {7'h00, $past(shown[0])};
    endproperty
    a_ecat_read: assert property (p_ecat_read) else $error("Subindex read wrong.");

    property p_no_output;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_in && !rd_in && !od_rd_in |=> !rvalid_out;
    endproperty
    a_no_output: assert property (p_no_output) else $error("Write caused a response.");

    property p_filter_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        $changed(st.stable[0]) && st.valid[0] && $past(st.valid[0]) |-> $past(st.cnt[0]) == FILT_MAX;
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("Level accepted early.");

    property p_led;
        @(posedge clk_in) disable iff (!rst_n_in)
        ##1 channel_led_out == $past(shown);
    endproperty
    a_led: assert property (p_led) else $error("Indicator mismatch.");

    property p_bus_loss;
        @(posedge clk_in) disable iff (!rst_n_in)
        !bus_ok_in && !config_err_in |=> !run_indicator_out && module_fault_indicator_out;
    endproperty
    a_bus_loss: assert property (p_bus_loss) else $error("Bus loss pattern wrong.");

    property p_flash;
        @(posedge clk_in) disable iff (!rst_n_in)
        config_err_in |=> run_indicator_out == module_fault_indicator_out;
    endproperty
    a_flash: assert property (p_flash) else $error("Flash pattern wrong.");

    property p_reset_zero;
        @(posedge clk_in) !rst_n_in |=> input_state_byte_out == 8'h00 ##1 input_state_byte_out == 8'h00;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("Input not zero after reset.");

    property p_rvalid_pulse;
        @(posedge clk_in) disable iff (!rst_n_in)
        1'b1 |=> rvalid_out == $past(rd_in || od_rd_in);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("Read answer not one cycle later.");

    property p_bad_addr;
        @(posedge clk_in) disable iff (!rst_n_in)
        rd_in && addr_in != FDI_OFS_INPUT_STATE |=> rerr_out && rdata_out == 8'h00;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("Unmapped offset not refused.");

    property p_bad_index;
        @(posedge clk_in) disable iff (!rst_n_in)
        od_rd_in && !rd_in && !od_ecat_in && object_index_in != FDI_IDX_INPUT |=> rerr_out;
    endproperty
    a_bad_index: assert property (p_bad_index) else $error("Unknown object not refused.");

    property p_bad_slot;
        @(posedge clk_in) disable iff (!rst_n_in)
        od_rd_in && !rd_in && od_ecat_in && object_index_in != ecat_index |=> rerr_out;
    endproperty
    a_bad_slot: assert property (p_bad_slot) else $error("Wrong slot index not refused.");

    property p_bad_sub;
        @(posedge clk_in) disable iff (!rst_n_in)
        od_rd_in && !rd_in && od_ecat_in
        && (object_subindex_in < FDI_SUB_FIRST || object_subindex_in > FDI_SUB_LAST) |=> rerr_out;
    endproperty
    a_bad_sub: assert property (p_bad_sub) else $error("Subindex out of range not refused.");

    property p_normal_ind;
        @(posedge clk_in) disable iff (!rst_n_in)
        bus_ok_in && !config_err_in
        |=> run_indicator_out && module_fault_indicator_out == $past(module_err_in);
    endproperty
    a_normal_ind: assert property (p_normal_ind) else $error("Normal indicator pattern wrong.");

    property p_flash_span;
        @(posedge clk_in) disable iff (!rst_n_in)
        st.flash_cnt <= FLASH_MAX;
    endproperty
    a_flash_span: assert property (p_flash_span) else $error("Flash counter out of range.");

    property p_same_byte;
        @(posedge clk_in) disable iff (!rst_n_in)
        input_state_byte_out == channel_led_out;
    endproperty
    a_same_byte: assert property (p_same_byte) else $error("Indicators differ from input byte.");

    property p_reset_quiet;
        @(posedge clk_in)
        !rst_n_in |=> !rvalid_out && !rerr_out && rdata_out == 8'h00 && channel_led_out == 8'h00;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("Outputs not quiet after reset.");

    ////////////////////////////////////////////////////////////////////////
    // Each channel is checked on its own, since one shared counter would hide a crossed lane.
    generate
        for (genvar ch = 0; ch < FDI_NUM_CH; ch++) begin : g_ch
            property p_ch_hold;
                @(posedge clk_in) disable iff (!rst_n_in)
                st.valid[ch] && $past(st.valid[ch]) && $changed(st.stable[ch]) |-> $past(st.cnt[ch]) == FILT_MAX;
            endproperty
            a_ch_hold: assert property (p_ch_hold) else $error("Channel level accepted early.");

            property p_ch_glitch;
                @(posedge clk_in) disable iff (!rst_n_in)
                st.valid[ch] && input_channel_in[ch] == st.stable[ch] |=> $stable(st.stable[ch]);
            endproperty
            a_ch_glitch: assert property (p_ch_glitch) else $error("Channel level moved while input agreed.");

            property p_ch_cnt;
                @(posedge clk_in) disable iff (!rst_n_in)
                st.cnt[ch] <= FILT_MAX;
            endproperty
            a_ch_cnt: assert property (p_ch_cnt) else $error("Filter counter out of range.");

            property p_ch_sticky;
                @(posedge clk_in) disable iff (!rst_n_in)
                st.valid[ch] |=> st.valid[ch];
            endproperty
            a_ch_sticky: assert property (p_ch_sticky) else $error("Channel lost its valid state.");

            property p_ch_sub;
                @(posedge clk_in) disable iff (!rst_n_in)
                od_rd_in && !rd_in && od_ecat_in && object_index_in == ecat_index && object_subindex_in == 8'(ch + 1)
                |=> !rerr_out && rdata_out == {7'h00, $past(shown[ch])};
            endproperty
            a_ch_sub: assert property (p_ch_sub) else $error("Channel subindex read wrong.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    c_byte_read: cover property (@(posedge clk_in) rd_in ##1 rvalid_out && rdata_out != 8'h00);
    c_ecat: cover property (@(posedge clk_in) od_rd_in && od_ecat_in ##1 rvalid_out && !rerr_out);
    c_flash: cover property (@(posedge clk_in) config_err_in && $rose(st.flash));
    c_bad: cover property (@(posedge clk_in) rerr_out);
    c_accept: cover property (@(posedge clk_in) st.valid[0] && $changed(st.stable[0]));
endmodule : fdi_input_port

/* File: verilog/fdi_pkg.sv */
// Package with constants of the filtered eight-channel input port.
package fdi_pkg;
    localparam int          FDI_CLK_HZ          = 40_000_000;
    localparam int          FDI_NUM_CH          = 8;
    localparam int          FDI_DELAY_STD_US    = 3000;
    localparam int          FDI_DELAY_FAST_US   = 500;
    localparam int          FDI_CYC_STD         = FDI_CLK_HZ / 1_000_000 * FDI_DELAY_STD_US;
    localparam int          FDI_CYC_FAST        = FDI_CLK_HZ / 1_000_000 * FDI_DELAY_FAST_US;
    localparam int          FDI_CNT_W           = 17;
    localparam logic [7:0]  FDI_OFS_INPUT_STATE = 8'h00;
    localparam logic [15:0] FDI_IDX_INPUT       = 16'h6000;
    localparam logic [7:0]  FDI_SUB_FIRST       = 8'h01;
    localparam logic [7:0]  FDI_SUB_LAST        = 8'h08;
    localparam logic [7:0]  FDI_INPUT_RESET     = 8'h00;
    localparam int          FDI_FLASH_HALF_US   = 250_000;
    localparam int          FDI_FLASH_CYC       = FDI_CLK_HZ / 1_000_000 * FDI_FLASH_HALF_US;
    localparam int          FDI_FLASH_W         = 24;
    // Identity code of the port; the value is arbitrary.
    localparam logic [7:0]  FDI_MODULE_ID       = 8'h5A;
endpackage : fdi_pkg

/* File: verif/fdi_head_model.sv */
// Head module model that issues byte image and object reads to the input port.
`timescale 1ns/10ps
module fdi_head_model (
    input  wire logic        clk_in,
    input  wire logic [7:0]  rdata_in,
    input  wire logic        rvalid_in,
    input  wire logic        rerr_in,
    output logic             rd_out,
    output logic [7:0]       addr_out,
    output logic             od_rd_out,
    output logic [15:0]      index_out,
    output logic [7:0]       sub_out,
    output logic [7:0]       slot_out,
    output logic             ecat_out
);
    initial begin
        {rd_out, od_rd_out, ecat_out, addr_out, index_out, sub_out, slot_out} = '0;
    end
    // One strobe per call; released fields are inverted so a stale decode cannot pass unseen.
    task automatic read(input logic od, ec, input logic [7:0] a, input logic [15:0] ix, input logic [7:0] sx, sl,
                        output logic [7:0] d, output logic v, e);
        @(posedge clk_in);
        {rd_out, od_rd_out, ecat_out, addr_out, index_out, sub_out, slot_out} <= {!od, od, ec, a, ix, sx, sl};
        @(posedge clk_in);
        {rd_out, od_rd_out, addr_out, index_out, sub_out} <= {2'b00, ~a, ~ix, ~sx};
        @(posedge clk_in);
        {d, v, e} = {rdata_in, rvalid_in, rerr_in};
    endtask : read
endmodule : fdi_head_model

/* File: verif/fdi_input_port_bench.sv */
// Self-checking bench of the filtered eight-channel input port.
`timescale 1ns/10ps
module fdi_input_port_bench;
    import fdi_pkg::*;
    localparam int N = 8;
    logic        clk_in, rst_n_in, wr_in, bus_ok_in, module_err_in, config_err_in, rd_in, od_rd_in, od_ecat_in;
    logic [7:0]  input_channel_in, wdata_in, addr_in, object_subindex_in, ecat_slot_in, exp_byte;
    logic [15:0] object_index_in;
    logic [7:0]  rdata_out, input_state_byte_out, channel_led_out;
    logic        rvalid_out, rerr_out, run_indicator_out, module_fault_indicator_out;
    logic [31:0] r;
    integer      seed = 32'h3709;
    int          err_total, num_checks, tog;
    fdi_input_port #(.FAST_VARIANT(1'b0), .STD_CYCLES(N), .FAST_CYCLES(4), .FLASH_CYCLES(4)) fdi_input_port_inst (
        .clk_in, .rst_n_in, .input_channel_in, .rd_in, .addr_in, .od_rd_in, .object_index_in, .object_subindex_in,
        .ecat_slot_in, .od_ecat_in, .wr_in, .wdata_in, .bus_ok_in, .module_err_in, .config_err_in, .rdata_out,
        .rvalid_out, .rerr_out, .input_state_byte_out, .channel_led_out, .run_indicator_out, .module_fault_indicator_out);
    fdi_head_model fdi_head_model_inst (.clk_in(clk_in), .rdata_in(rdata_out), .rvalid_in(rvalid_out),
        .rerr_in(rerr_out), .rd_out(rd_in), .addr_out(addr_in), .od_rd_out(od_rd_in), .index_out(object_index_in),
        .sub_out(object_subindex_in), .slot_out(ecat_slot_in), .ecat_out(od_ecat_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Bit 8 of the result flags a refused request.
    function automatic logic [8:0] exp_read(input logic od, ec, input logic [7:0] a, input logic [15:0] ix,
                                            input logic [7:0] sx, sl);
        if (!od) return (a == 8'h00) ? {1'b0, exp_byte} : 9'h100;
        if (!ec) return (ix == 16'h6000) ? {1'b0, exp_byte} : 9'h100;
        if (ix == 16'h6000 + sl && sx >= 8'h01 && sx <= 8'h08) return {8'h00, exp_byte[sx - 8'h01]};
        return 9'h100;
    endfunction : exp_read
    task automatic do_rd(input logic od, ec, input logic [7:0] a, input logic [15:0] ix, input logic [7:0] sx, sl);
        logic [8:0] e;
        logic [7:0] gd;
        logic       gv, ge;
        e = exp_read(od, ec, a, ix, sx, sl);
        fdi_head_model_inst.read(od, ec, a, ix, sx, sl, gd, gv, ge);
        check("rvalid", {7'h00, gv}, 8'h01);
        check("rerr", {7'h00, ge}, {7'h00, e[8]});
        check("rdata", gd, e[7:0]);
    endtask : do_rd
    // Head writes run alongside every change to show they never reach the input byte.
    task automatic apply(input logic [7:0] v);
        input_channel_in <= v;
        wr_in <= 1'b1;
        wdata_in <= 8'($random(seed));
        repeat (N) @(posedge clk_in);
        check("hold", input_state_byte_out, exp_byte);
        repeat (2) @(posedge clk_in);
        exp_byte = v;
        check("byte", input_state_byte_out, exp_byte);
        check("led", channel_led_out, exp_byte);
    endtask : apply
    task automatic ind(input logic [2:0] cfg, input logic [1:0] exp);
        {config_err_in, bus_ok_in, module_err_in} <= cfg;
        repeat (3) @(posedge clk_in);
        check("ind", {6'h00, run_indicator_out, module_fault_indicator_out}, {6'h00, exp});
    endtask : ind
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        #(25 * 20000);
        err_total++;
        final_report();
    end
    initial begin
        {rst_n_in, wr_in, wdata_in, module_err_in, config_err_in, exp_byte} = '0;
        {bus_ok_in, input_channel_in} = 9'h1A5;
        repeat (20) @(posedge clk_in);
        check("rst_byte", input_state_byte_out, 8'h00);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check("rst_led", channel_led_out, 8'h00);
        repeat (N + 2) @(posedge clk_in);
        exp_byte = 8'hA5;
        check("settle", input_state_byte_out, exp_byte);
        $display("reset test done");
        apply(8'h00);
        apply(8'hFF);
        input_channel_in <= 8'h00;
        repeat (N - 1) @(posedge clk_in);
        apply(8'hFF);
        apply(8'h5A);
        $display("filter test done");
        for (int k = 0; k < 10; k++) do_rd(1'b1, 1'b1, 8'h00, 16'h6003, k[7:0], 8'h03);
        do_rd(1'b0, 1'b0, 8'h01, 16'h6000, 8'h00, 8'h00);
        do_rd(1'b1, 1'b0, 8'h00, 16'h6001, 8'h00, 8'h00);
        do_rd(1'b0, 1'b0, 8'h00, 16'h0000, 8'h00, 8'h00);
        do_rd(1'b1, 1'b0, 8'h00, 16'h6000, 8'h00, 8'h00);
        $display("read test done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            apply(r[31:24]);
            do_rd(r[0], r[1], {7'h00, r[2] & r[3]}, 16'h6000 + (r[4] ? 16'h0000 : {8'h00, r[15:8]}),
                  {4'h0, r[19:16] % 4'hA}, r[15:8]);
        end
        $display("random test done");
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check("mid_rst", input_state_byte_out, 8'h00);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        check("mid_rst_led", channel_led_out, 8'h00);
        repeat (N + 2) @(posedge clk_in);
        check("mid_settle", input_state_byte_out, exp_byte);
        $display("mid reset test done");
        ind(3'b010, 2'b10);
        ind(3'b011, 2'b11);
        ind(3'b001, 2'b01);
        ind(3'b000, 2'b01);
        {config_err_in, bus_ok_in, module_err_in} <= 3'b110;
        repeat (2) @(posedge clk_in);
        tog = 0;
        for (int c = 0; c < 12; c++) begin
            @(posedge clk_in);
            tog += int'(run_indicator_out);
            check("flash_pair", {7'h00, run_indicator_out}, {7'h00, module_fault_indicator_out});
        end
        check("flash_toggle", {7'h00, tog > 0 && tog < 12}, 8'h01);
        $display("indicator test done");
        final_report();
    end
endmodule : fdi_input_port_bench
